// >>> design/stepper_param_bank.v
// Parameter register bank and supervision logic of a stepper drive.
//
// Summary of operation
// - Open-loop run current in mA drives the winding; default 3000, 0..6000.
// - Open-loop standby cuts current to a percentage; default 50, 0..100.
// - Standby starts after no pulse for set ms; default 500, 10..65535.
// - Pulse command filter time is value times 50 us; default 128, 1..512.
// - Read-only register reports encoder position as a pulse count.
// - Auto gain: 1 identifies motor and makes gains; 0 uses user values.
// - Identified winding resistance in milliohms is readable only.
// - Identified winding inductance in millihenries is readable only.
// - User R and L apply only with auto gain off; defaults 1000 and 1.
// - Current-loop Kp is generated in auto mode, else user-writable.
// - Current-loop Ki is generated in auto mode, else user-writable.
// - Current-loop compensation coefficient; default 256, range 0..1024.
// - Writing 1 starts a step test from zero to 1000 mA; reads give 0.
// - Encoder is decoded times four; resolution default 4000, 256..65535.
// - Closed-loop tracking alarm when position error exceeds threshold; default 2000.
// - In window when position error is at most the window; default 10.
// - Done only after staying in window hold count times 50 us.
// - After pulses stop, wait delay count times 50 us before judging.
// - Closed-loop peak current limited to set mA; default 4000, 0..5000.
// - Closed-loop base current percentage; default 50, 0..100.
// - Two speed feedback filter cutoffs in Hz; defaults 200 and 600.
// - Running mode 0 is open loop; 1 and 2 are the servo modes.
`include "stepper_param_regs.vh"

module stepper_param_bank #(
    parameter SHORT_TICK = `TICK_SHORT_NS / `CLK_PERIOD_NS,
    parameter LONG_TICK  = `TICK_LONG_NS / `CLK_PERIOD_NS
) (
    // Clock, reset and enable
    input  wire        clk_sys,
    input  wire        rst,
    input  wire        ce,
    // Holding register port
    input  wire [15:0] regAddr,
    input  wire        regWrite,
    input  wire        regRead,
    input  wire [15:0] regWdata,
    output reg  [15:0] regRdata,
    output reg         regAck,
    output reg         regRejected,
    // Pins
    input  wire        cmdPulsePin,
    input  wire        encAPin,
    input  wire        encBPin,
    // Control core inputs
    input  wire [15:0] positionError,
    input  wire [15:0] motorSpeed,
    input  wire        identValid,
    input  wire [15:0] identResistance,
    input  wire [15:0] identInductance,
    input  wire        autoGainValid,
    input  wire [15:0] autoPropGain,
    input  wire [15:0] autoIntGain,
    // Control core outputs
    output reg         openLoop,
    output reg         inStandby,
    output reg  [15:0] currentCommand,
    output reg  [15:0] baseCurrentPercent,
    output reg  [15:0] filterTicks,
    output reg         autoGain,
    output reg  [15:0] activeResistance,
    output reg  [15:0] activeInductance,
    output reg  [15:0] propGain,
    output reg  [15:0] intGain,
    output reg  [10:0] compCoef,
    output reg         stepTestStart,
    output reg  [15:0] stepTestCurrent,
    output reg  [15:0] encoderResolution,
    output reg         trackingAlarm,
    output reg         inWindow,
    output reg         positionDone,
    output reg  [15:0] speedFilterOne,
    output reg  [15:0] speedFilterTwo
);

// ********************************************************************
// Stored parameters
// ********************************************************************
reg [15:0] runMode;
reg [15:0] runCurrent;
reg [15:0] standbyPercent;
reg [15:0] standbyDelay;
reg [15:0] userResistance;
reg [15:0] userInductance;
reg [15:0] idResistance;
reg [15:0] idInductance;
reg [15:0] trackThreshold;
reg [15:0] doneWindow;
reg [15:0] doneHold;
reg [15:0] checkDelay;
reg [15:0] maxCurrent;
reg [15:0] encoderCount;
reg [15:0] feedbackSpeed;

// ********************************************************************
// Pin synchronisers and edge detection
// ********************************************************************
reg [1:0] pulseSync;
reg [1:0] aSync;
reg [1:0] bSync;
reg       pulseLast;
reg       aLast;
reg       bLast;

always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
        pulseSync <= 2'h0;
        aSync     <= 2'h0;
        bSync     <= 2'h0;
        pulseLast <= 1'b0;
        aLast     <= 1'b0;
        bLast     <= 1'b0;
    end else if (ce) begin
        pulseSync <= {pulseSync[0], cmdPulsePin};
        aSync     <= {aSync[0], encAPin};
        bSync     <= {bSync[0], encBPin};
        pulseLast <= pulseSync[1];
        aLast     <= aSync[1];
        bLast     <= bSync[1];
    end
end

wire pulseEdge = pulseSync[1] & ~pulseLast;
// Every edge of either phase counts, which gives the fourfold resolution.
wire encStep   = (aSync[1] ^ aLast) | (bSync[1] ^ bLast);
wire encUp     = aSync[1] ^ bLast;

// ********************************************************************
// Time base
// ********************************************************************
reg [31:0] shortCnt;
reg [31:0] longCnt;
wire       shortTick = (shortCnt == SHORT_TICK - 1);
wire       longTick  = (longCnt == LONG_TICK - 1);

always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
        shortCnt <= 32'h0;
        longCnt  <= 32'h0;
    end else if (ce) begin
        shortCnt <= shortTick ? 32'h0 : shortCnt + 32'h1;
        longCnt  <= longTick ? 32'h0 : longCnt + 32'h1;
    end
end

// ********************************************************************
// Write range check
// ********************************************************************
reg wrOk;

always @* begin
    case (regAddr)
        `ADDR_RUN_MODE:     wrOk = regWdata <= `MAX_RUN_MODE;
        `ADDR_RUN_CURRENT:  wrOk = regWdata <= `MAX_RUN_CURRENT;
        `ADDR_STBY_PERCENT: wrOk = regWdata <= `MAX_PERCENT;
        `ADDR_STBY_DELAY:   wrOk = regWdata >= `MIN_STBY_DELAY;
        `ADDR_PULSE_FILTER: wrOk = regWdata >= `MIN_ONE &&
                                   regWdata <= `MAX_PULSE_FILTER;
        `ADDR_AUTO_GAIN:    wrOk = regWdata <= `MIN_ONE;
        `ADDR_USER_RES:     wrOk = regWdata >= `MIN_USER_RES &&
                                   regWdata <= `MAX_USER_RES;
        `ADDR_USER_IND:     wrOk = regWdata >= `MIN_ONE &&
                                   regWdata <= `MAX_USER_IND;
        `ADDR_PROP_GAIN:    wrOk = !autoGain &&
                                   regWdata >= `MIN_PROP_GAIN &&
                                   regWdata <= `MAX_PROP_GAIN;
        `ADDR_INT_GAIN:     wrOk = !autoGain &&
                                   regWdata <= `MAX_INT_GAIN;
        `ADDR_COMP_COEF:    wrOk = regWdata <= `MAX_COMP_COEF;
        `ADDR_STEP_TEST:    wrOk = regWdata <= `MIN_ONE;
        `ADDR_ENC_RES:      wrOk = regWdata >= `MIN_ENC_RES;
        `ADDR_TRACK_THRESH: wrOk = regWdata >= `MIN_TRACK_THRESH;
        `ADDR_DONE_WINDOW:  wrOk = regWdata >= `MIN_ONE;
        `ADDR_DONE_HOLD:    wrOk = regWdata >= `MIN_ONE;
        `ADDR_CHECK_DELAY:  wrOk = regWdata >= `MIN_ONE;
        `ADDR_CL_MAX_CUR:   wrOk = regWdata <= `MAX_CL_CUR;
        `ADDR_CL_BASE_CUR:  wrOk = regWdata <= `MAX_PERCENT;
        `ADDR_SPD_FILT_ONE,
        `ADDR_SPD_FILT_TWO: wrOk = regWdata >= `MIN_SPD_FILT &&
                                   regWdata <= `MAX_SPD_FILT;
        default:            wrOk = 1'b0;
    endcase
end

wire doWrite = regWrite && wrOk;

// ********************************************************************
// Register storage
// ********************************************************************
always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
        runMode            <= `RST_RUN_MODE;
        runCurrent         <= `RST_RUN_CURRENT;
        standbyPercent     <= `RST_STBY_PERCENT;
        standbyDelay       <= `RST_STBY_DELAY;
        filterTicks        <= `RST_PULSE_FILTER;
        autoGain           <= 1'b0;
        userResistance     <= `RST_USER_RES;
        userInductance     <= `RST_USER_IND;
        idResistance       <= 16'h0000;
        idInductance       <= 16'h0000;
        propGain           <= `RST_PROP_GAIN;
        intGain            <= `RST_INT_GAIN;
        compCoef           <= `RST_COMP_COEF;
        stepTestStart      <= 1'b0;
        stepTestCurrent    <= `STEP_TEST_MA;
        encoderResolution  <= `RST_ENC_RES;
        trackThreshold     <= `RST_TRACK_THRESH;
        doneWindow         <= `RST_DONE_WINDOW;
        doneHold           <= `RST_DONE_HOLD;
        checkDelay         <= `RST_CHECK_DELAY;
        maxCurrent         <= `RST_CL_MAX_CUR;
        baseCurrentPercent <= `RST_CL_BASE_CUR;
        speedFilterOne     <= `RST_SPD_FILT_ONE;
        speedFilterTwo     <= `RST_SPD_FILT_TWO;
        feedbackSpeed      <= 16'h0000;
    end else if (ce) begin
        stepTestStart <= 1'b0;
        feedbackSpeed <= motorSpeed;
        if (identValid) begin
            idResistance <= identResistance;
            idInductance <= identInductance;
        end
        // Generated gains overwrite the registers only in auto mode.
        if (autoGainValid && autoGain) begin
            propGain <= autoPropGain;
            intGain  <= autoIntGain;
        end
        if (doWrite) begin
            case (regAddr)
                `ADDR_RUN_MODE:     runMode <= regWdata;
                `ADDR_RUN_CURRENT:  runCurrent <= regWdata;
                `ADDR_STBY_PERCENT: standbyPercent <= regWdata;
                `ADDR_STBY_DELAY:   standbyDelay <= regWdata;
                `ADDR_PULSE_FILTER: filterTicks <= regWdata;
                `ADDR_AUTO_GAIN:    autoGain <= regWdata[0];
                `ADDR_USER_RES:     userResistance <= regWdata;
                `ADDR_USER_IND:     userInductance <= regWdata;
                `ADDR_PROP_GAIN:    propGain <= regWdata;
                `ADDR_INT_GAIN:     intGain <= regWdata;
                `ADDR_COMP_COEF:    compCoef <= regWdata[10:0];
                `ADDR_STEP_TEST:    stepTestStart <= regWdata[0];
                `ADDR_ENC_RES:      encoderResolution <= regWdata;
                `ADDR_TRACK_THRESH: trackThreshold <= regWdata;
                `ADDR_DONE_WINDOW:  doneWindow <= regWdata;
                `ADDR_DONE_HOLD:    doneHold <= regWdata;
                `ADDR_CHECK_DELAY:  checkDelay <= regWdata;
                `ADDR_CL_MAX_CUR:   maxCurrent <= regWdata;
                `ADDR_CL_BASE_CUR:  baseCurrentPercent <= regWdata;
                `ADDR_SPD_FILT_ONE: speedFilterOne <= regWdata;
                `ADDR_SPD_FILT_TWO: speedFilterTwo <= regWdata;
                default:            runMode <= runMode;
            endcase
        end
    end
end

// ********************************************************************
// Read path
// ********************************************************************
reg [15:0] readMux;
reg        readHit;

always @* begin
    readHit = 1'b1;
    case (regAddr)
        `ADDR_RUN_MODE:     readMux = runMode;
        `ADDR_RUN_CURRENT:  readMux = runCurrent;
        `ADDR_STBY_PERCENT: readMux = standbyPercent;
        `ADDR_STBY_DELAY:   readMux = standbyDelay;
        `ADDR_PULSE_FILTER: readMux = filterTicks;
        `ADDR_ENC_POSITION: readMux = encoderCount;
        `ADDR_AUTO_GAIN:    readMux = {15'h0000, autoGain};
        `ADDR_ID_RES:       readMux = idResistance;
        `ADDR_ID_IND:       readMux = idInductance;
        `ADDR_USER_RES:     readMux = userResistance;
        `ADDR_USER_IND:     readMux = userInductance;
        `ADDR_PROP_GAIN:    readMux = propGain;
        `ADDR_INT_GAIN:     readMux = intGain;
        `ADDR_COMP_COEF:    readMux = {5'h00, compCoef};
        `ADDR_STEP_TEST:    readMux = 16'h0000;
        `ADDR_ENC_RES:      readMux = encoderResolution;
        `ADDR_TRACK_THRESH: readMux = trackThreshold;
        `ADDR_DONE_WINDOW:  readMux = doneWindow;
        `ADDR_DONE_HOLD:    readMux = doneHold;
        `ADDR_CHECK_DELAY:  readMux = checkDelay;
        `ADDR_CL_MAX_CUR:   readMux = maxCurrent;
        `ADDR_CL_BASE_CUR:  readMux = baseCurrentPercent;
        `ADDR_SPD_FILT_ONE: readMux = speedFilterOne;
        `ADDR_SPD_FILT_TWO: readMux = speedFilterTwo;
        `ADDR_FB_SPEED:     readMux = feedbackSpeed;
        default: begin
            readMux = 16'h0000;
            readHit = 1'b0;
        end
    endcase
end

always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
        regRdata    <= 16'h0000;
        regAck      <= 1'b0;
        regRejected <= 1'b0;
    end else if (ce) begin
        regAck      <= regRead | regWrite;
        regRejected <= (regWrite & ~wrOk) | (regRead & ~readHit);
        if (regRead) begin
            regRdata <= readMux;
        end
    end
end

// ********************************************************************
// Encoder position and pulse idle timing
// ********************************************************************
reg [15:0] idleMs;
reg [15:0] idleShort;

always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
        encoderCount <= 16'h0000;
        idleMs       <= 16'h0000;
        idleShort    <= 16'h0000;
    end else if (ce) begin
        if (encStep) begin
            encoderCount <= encUp ? encoderCount + 16'h0001
                                  : encoderCount - 16'h0001;
        end
        // Both idle counters saturate so a long pause never wraps.
        if (pulseEdge) begin
            idleMs    <= 16'h0000;
            idleShort <= 16'h0000;
        end else begin
            if (longTick && idleMs != 16'hFFFF) begin
                idleMs <= idleMs + 16'h0001;
            end
            if (shortTick && idleShort != 16'hFFFF) begin
                idleShort <= idleShort + 16'h0001;
            end
        end
    end
end

// ********************************************************************
// Current command and mode
// ********************************************************************
wire        isOpen      = (runMode == `MODE_OPEN_LOOP);
wire        stbyNow     = isOpen && (idleMs >= standbyDelay);
wire [20:0] stbyProduct = runCurrent[12:0] * standbyPercent[7:0];
wire [20:0] stbyCurrent = stbyProduct / `PERCENT_DIV;

always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
        openLoop         <= 1'b1;
        inStandby        <= 1'b0;
        currentCommand   <= `RST_RUN_CURRENT;
        activeResistance <= `RST_USER_RES;
        activeInductance <= `RST_USER_IND;
    end else if (ce) begin
        openLoop  <= isOpen;
        inStandby <= stbyNow;
        if (!isOpen) begin
            currentCommand <= maxCurrent;
        end else if (stbyNow) begin
            currentCommand <= stbyCurrent[15:0];
        end else begin
            currentCommand <= runCurrent;
        end
        activeResistance <= autoGain ? idResistance : userResistance;
        activeInductance <= autoGain ? idInductance : userInductance;
    end
end

// ********************************************************************
// Position supervision
// ********************************************************************
reg [15:0] holdCnt;
wire       winNow   = positionError <= doneWindow;
wire       checking = !isOpen && (idleShort >= checkDelay);

always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
        trackingAlarm <= 1'b0;
        inWindow      <= 1'b0;
        positionDone  <= 1'b0;
        holdCnt       <= 16'h0000;
    end else if (ce) begin
        trackingAlarm <= !isOpen && (positionError > trackThreshold);
        inWindow      <= winNow;
        // Leaving the window or a new pulse restarts the hold time.
        if (!checking || !winNow || pulseEdge) begin
            holdCnt      <= 16'h0000;
            positionDone <= 1'b0;
        end else if (holdCnt >= doneHold) begin
            positionDone <= 1'b1;
        end else if (shortTick) begin
            holdCnt <= holdCnt + 16'h0001;
        end
    end
end

endmodule // stepper_param_bank

// >>> design/stepper_param_regs.vh
// Register addresses, reset values, ranges and timing constants.
`ifndef STEPPER_PARAM_REGS_VH
`define STEPPER_PARAM_REGS_VH

// ********************************************************************
// Holding register addresses
// ********************************************************************
`define ADDR_RUN_MODE        16'h0016
`define ADDR_RUN_CURRENT     16'h0019
`define ADDR_STBY_PERCENT    16'h001A
`define ADDR_STBY_DELAY      16'h001B
`define ADDR_PULSE_FILTER    16'h001C
`define ADDR_ENC_POSITION    16'h001D
`define ADDR_AUTO_GAIN       16'h001E
`define ADDR_ID_RES          16'h001F
`define ADDR_ID_IND          16'h0020
`define ADDR_USER_RES        16'h0021
`define ADDR_USER_IND        16'h0022
`define ADDR_PROP_GAIN       16'h0024
`define ADDR_INT_GAIN        16'h0025
`define ADDR_COMP_COEF       16'h0026
`define ADDR_STEP_TEST       16'h0027
`define ADDR_ENC_RES         16'h0028
`define ADDR_TRACK_THRESH    16'h0029
`define ADDR_DONE_WINDOW     16'h002A
`define ADDR_DONE_HOLD       16'h002B
`define ADDR_CHECK_DELAY     16'h002C
`define ADDR_CL_MAX_CUR      16'h002D
`define ADDR_CL_BASE_CUR     16'h002E
`define ADDR_SPD_FILT_ONE    16'h002F
`define ADDR_SPD_FILT_TWO    16'h0030
`define ADDR_FB_SPEED        16'h00D5

// ********************************************************************
// Reset values
// ********************************************************************
`define RST_RUN_MODE         16'h0000
`define RST_RUN_CURRENT      16'h0BB8
`define RST_STBY_PERCENT     16'h0032
`define RST_STBY_DELAY       16'h01F4
`define RST_PULSE_FILTER     16'h0080
`define RST_AUTO_GAIN        16'h0000
`define RST_USER_RES         16'h03E8
`define RST_USER_IND         16'h0001
`define RST_PROP_GAIN        16'h03E8
`define RST_INT_GAIN         16'h00C8
`define RST_COMP_COEF        11'h100
`define RST_ENC_RES          16'h0FA0
`define RST_TRACK_THRESH     16'h07D0
`define RST_DONE_WINDOW      16'h000A
`define RST_DONE_HOLD        16'h0032
`define RST_CHECK_DELAY      16'h0064
`define RST_CL_MAX_CUR       16'h0FA0
`define RST_CL_BASE_CUR      16'h0032
`define RST_SPD_FILT_ONE     16'h00C8
`define RST_SPD_FILT_TWO     16'h0258

// ********************************************************************
// Accepted write ranges
// ********************************************************************
`define MAX_RUN_MODE         16'h0002
`define MAX_RUN_CURRENT      16'h1770
`define MAX_PERCENT          16'h0064
`define MIN_STBY_DELAY       16'h000A
`define MIN_ONE              16'h0001
`define MAX_PULSE_FILTER     16'h0200
`define MIN_USER_RES         16'h0064
`define MAX_USER_RES         16'h2710
`define MAX_USER_IND         16'h000A
`define MIN_PROP_GAIN        16'h00C8
`define MAX_PROP_GAIN        16'h2710
`define MAX_INT_GAIN         16'h07D0
`define MAX_COMP_COEF        16'h0400
`define MIN_ENC_RES          16'h0100
`define MIN_TRACK_THRESH     16'h0064
`define MAX_CL_CUR           16'h1388
`define MIN_SPD_FILT         16'h000A
`define MAX_SPD_FILT         16'h1388

// ********************************************************************
// Encodings and timing
// ********************************************************************
`define MODE_OPEN_LOOP       16'h0000
`define STEP_TEST_MA         16'h03E8
`define PERCENT_DIV          21'h000064
`define CLK_PERIOD_NS        8
`define TICK_SHORT_NS        50000
`define TICK_LONG_NS         1000000

`endif

// >>> testbench/stepper_param_bank_checker.sv
// Assertions on the parameter bank's register port and status outputs.
module stepper_param_bank_checker (
    input wire        clk_sys,
    input wire        rst,
    input wire        ce,
    input wire [15:0] regAddr,
    input wire        regWrite,
    input wire        regRead,
    input wire [15:0] regWdata,
    input wire [15:0] regRdata,
    input wire        regAck,
    input wire        regRejected,
    input wire [15:0] positionError,
    input wire        autoGain,
    input wire [15:0] stepTestCurrent,
    input wire        trackingAlarm,
    input wire        inWindow,
    input wire        positionDone
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    sequence s_wr(a); ce && regWrite && regAddr == a; endsequence
    sequence s_refused; regAck && regRejected; endsequence
    property p_ack; ce && (regWrite || regRead) |=> regAck; endproperty
    a_ack: assert property (p_ack) else $error("No ack.");
    property p_ro; s_wr(16'h1D) |=> s_refused; endproperty
    a_ro: assert property (p_ro) else $error("RO write taken.");
    property p_run; s_wr(16'h19) ##0 regWdata > 16'h1770 |=> s_refused;
    endproperty
    a_run: assert property (p_run) else $error("Run current range.");
    property p_pct; s_wr(16'h1A) ##0 regWdata > 16'h64 |=> s_refused;
    endproperty
    a_pct: assert property (p_pct) else $error("Percent range.");
    property p_lock; s_wr(16'h24) ##0 autoGain |=> s_refused; endproperty
    a_lock: assert property (p_lock) else $error("Gain not locked.");
    property p_unm; ce && regRead && regAddr == 16'h3 |=> s_refused
        and regRdata == 16'h0; endproperty
    a_unm: assert property (p_unm) else $error("Unmapped read.");
    property p_step; stepTestCurrent == 16'h3E8; endproperty
    a_step: assert property (p_step) else $error("Step target.");
    property p_alm; ce && positionError < 16'h64 |=> !trackingAlarm;
    endproperty
    a_alm: assert property (p_alm) else $error("False alarm.");
    property p_win; ce && positionError == 16'h0 |=> inWindow; endproperty
    a_win: assert property (p_win) else $error("Window lost.");
    property p_done; $rose(positionDone) |-> $past(inWindow); endproperty
    a_done: assert property (p_done) else $error("Early done.");
endmodule // stepper_param_bank_checker

bind stepper_param_bank stepper_param_bank_checker i_chk (.clk_sys, .rst,
    .ce, .regAddr, .regWrite, .regRead, .regWdata, .regRdata, .regAck,
    .regRejected, .positionError, .autoGain, .stepTestCurrent,
    .trackingAlarm, .inWindow, .positionDone);

// >>> testbench/reg_host.sv
// Network host model that reads and writes the holding registers.
module reg_host (
    input  wire         clk_sys,
    input  wire  [15:0] regRdata,
    input  wire         regAck,
    input  wire         regRejected,
    output logic [15:0] regAddr,
    output logic        regWrite,
    output logic        regRead,
    output logic [15:0] regWdata
);
    timeunit 1ns;
    timeprecision 1ps;
    initial {regAddr, regWrite, regRead, regWdata} = 34'h0;
    task automatic xfer(input bit w, input logic [15:0] a, d,
                        output logic [15:0] rd, output logic rj);
        @(posedge clk_sys);
        #1 {regWrite, regRead, regAddr, regWdata} = {w, !w, a, d};
        @(posedge clk_sys);
        // An idle bus shows the inverse, so stale values never match.
        #1 {regWrite, regRead, regAddr, regWdata} = {2'b00, ~a, ~d};
        rd = regRdata;
        rj = regAck === 1'b1 ? regRejected : 1'bx;
    endtask
endmodule // reg_host

// >>> testbench/tb_stepper_param_bank.sv
// Self-checking bench of the stepper drive parameter bank.
module tb_stepper_param_bank;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_sys = 0, rst = 1, pulse = 0, encA = 0, idV = 0, agV = 0;
    logic [15:0] posErr = 16'h0, rd, v, idR = 16'h0777, apg = 16'h0ABC;
    logic        rj, encB = 0;
    int          mismatches = 0, comparisons = 0, i;
    wire  [15:0] regAddr, regWdata, regRdata, cmd, pg, res;
    wire         regWrite, regRead, regAck, regRejected, ol, stb, alm, win, dn;
    wire         sts;
    logic [15:0] ad [18] = '{16'h19, 16'h1A, 16'h1B, 16'h1C, 16'h21, 16'h22,
        16'h24, 16'h25, 16'h26, 16'h28, 16'h29, 16'h2A, 16'h2B, 16'h2C,
        16'h2D, 16'h2E, 16'h2F, 16'h30};
    logic [15:0] lo [18] = '{0, 0, 10, 1, 100, 1, 200, 0, 0, 256, 100, 1,
        1, 1, 0, 0, 10, 10};
    logic [15:0] hi [18] = '{6000, 100, 65535, 512, 10000, 10, 10000, 2000,
        1024, 65535, 65535, 65535, 65535, 65535, 5000, 100, 5000, 5000};
    logic [15:0] ex [18] = '{3000, 50, 500, 128, 1000, 1, 1000, 200, 256,
        4000, 2000, 10, 50, 100, 4000, 50, 200, 600};
    always #4 clk_sys = ~clk_sys;
    stepper_param_bank #(.SHORT_TICK(4), .LONG_TICK(20)) i_stepper_param_bank (
        .clk_sys, .rst, .ce(1'b1), .regAddr, .regWrite, .regRead, .regWdata,
        .regRdata, .regAck, .regRejected, .cmdPulsePin(pulse), .encAPin(encA),
        .encBPin(encB), .positionError(posErr), .motorSpeed(apg),
        .identValid(idV), .identResistance(idR), .identInductance(~idR),
        .autoGainValid(agV), .autoPropGain(apg), .autoIntGain(idR),
        .openLoop(ol), .inStandby(stb), .currentCommand(cmd),
        .baseCurrentPercent(), .filterTicks(), .autoGain(),
        .activeResistance(res), .activeInductance(), .propGain(pg),
        .intGain(), .compCoef(), .stepTestStart(sts), .stepTestCurrent(),
        .encoderResolution(), .trackingAlarm(alm), .inWindow(win),
        .positionDone(dn), .speedFilterOne(), .speedFilterTwo());
    reg_host i_reg_host (.clk_sys, .regRdata, .regAck, .regRejected,
        .regAddr, .regWrite, .regRead, .regWdata);
    function automatic bit fits(int k, logic [15:0] x);
        return x >= lo[k] && x <= hi[k];
    endfunction
    task automatic chk(input logic [15:0] got, e);
        comparisons++;
        if (got !== e) begin
            mismatches++;
            $display("BAD %0t got %h expected %h", $time, got, e);
        end
    endtask
    task automatic wr(input logic [15:0] a, d, input bit r);
        i_reg_host.xfer(1, a, d, rd, rj);
        chk(16'(rj), 16'(r));
    endtask
    task automatic rdc(input logic [15:0] a, e);
        i_reg_host.xfer(0, a, 16'h0, rd, rj);
        chk({rd[15:1], rj ^ rd[0]}, e);
    endtask
    task automatic settle(int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task automatic print_verdict();
        $display("Comparisons %0d, mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        #200us mismatches++;
        print_verdict();
    end
    initial begin
        void'($urandom(22));
        settle(2);
        rst = 0;
        chk(cmd, 16'hBB8);
        for (i = 0; i < 18; i++) rdc(ad[i], ex[i]);
        for (int n = 0; n < 54; n++) begin
            i = n % 18;
            v = $urandom_range(2) ? 16'($urandom_range(hi[i], lo[i]))
                                  : 16'($urandom);
            wr(ad[i], v, !fits(i, v));
            if (fits(i, v)) ex[i] = v;
            rdc(ad[i], ex[i]);
        end
        wr(16'h19, 16'h1771, 1);
        wr(16'h19, 16'h1770, 0);
        wr(16'h1A, 16'h0065, 1);
        wr(16'h1A, 16'h0021, 0);
        wr(16'h1B, 16'h0009, 1);
        wr(16'h1B, 16'h000A, 0);
        wr(16'h1D, 16'h0000, 1);
        rdc(16'h0003, 16'h0001);
        wr(16'h27, 16'h0001, 0);
        chk(16'(sts), 16'h1);
        rdc(16'h27, 16'h0000);
        pulse = 1;
        settle(4);
        pulse = 0;
        settle(170);
        chk(cmd, 16'h1770);
        chk(16'(stb), 16'h0);
        for (int k = 0; k < 60 && stb !== 1'b1; k++) settle(1);
        chk(cmd, 16'(6000 * 33 / 100));
        chk(16'(stb), 16'h1);
        // One full forward quadrature cycle must count four steps.
        for (int k = 0; k < 4; k++) begin
            {encA, encB} = {~encB, encA};
            settle(4);
        end
        rdc(16'h1D, 16'h0004);
        wr(16'h16, 16'h0001, 0);
        settle(2);
        chk(cmd, ex[14]);
        chk(16'(ol), 16'h0);
        // Start outside the new window so the hold time restarts at zero.
        posErr = 16'h0006;
        wr(16'h29, 16'h0064, 0);
        wr(16'h2A, 16'h0005, 0);
        wr(16'h2C, 16'h0002, 0);
        wr(16'h2B, 16'h0003, 0);
        posErr = 16'h0005;
        settle(3);
        chk(16'({win, dn}), 16'h2);
        for (int k = 0; k < 60 && dn !== 1'b1; k++) settle(1);
        chk(16'(dn), 16'h1);
        posErr = 16'h0065;
        settle(3);
        chk(16'({alm, win, dn}), 16'h4);
        wr(16'h1E, 16'h0001, 0);
        wr(16'h24, 16'h03E8, 1);
        {agV, idV} = 2'b11;
        settle(1);
        {agV, idV} = 2'b00;
        settle(3);
        chk(pg, apg);
        chk(res, idR);
        rdc(16'h1F, idR);
        rdc(16'h20, ~idR);
        wr(16'h1E, 16'h0000, 0);
        settle(3);
        chk(res, ex[4]);
        print_verdict();
    end
endmodule // tb_stepper_param_bank
